// >>> ctr_pkg.sv
// Package for the cache test register port: field layouts, op codes,
// geometry constants. Assumes one core clock and synchronous reset.
package ctr_pkg;
  // Cache geometry
  localparam int WAYS       = 4;
  localparam int LINES      = 256;
  localparam int TAG_W      = 20;
  localparam int LINE_W     = 128;
  localparam int WORDS      = 4;
  localparam int IDX_W      = 8;
  // Test register selector codes on the register port
  localparam logic [1:0] REG_CMD  = 2'h0;
  localparam logic [1:0] REG_TAG  = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  // Command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_SEL_LSB  = 2;
  localparam int CMD_LINE_LSB = 4;
  // Tag/status register fields
  localparam int TS_TAG_LSB   = 12;
  localparam int TS_VALID_BIT = 10;
  localparam int TS_HIST_LSB  = 7;
  localparam int TS_DIRTY_LSB = 3;
  // Reset values
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] TS_RST  = 32'h0000_0000;
  // Operation codes
  typedef enum logic [1:0] {
    OP_BUF   = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_FLUSH = 2'b11
  } ctr_op_t;
endpackage

// >>> ctr_port.sv
// Cache test register port: command, tag/status and data registers
// with fill and flush buffers in front of a four-way cache array.
// Assumes the core presents one register access per cycle with the
// current privilege level and a real-mode flag alongside it.
//
// Operation
// RQ1 - Test registers reachable only at level zero; the port also allows access in real mode at any cpl
// RQ2 - Sixteen KB four-way write-back cache
// RQ3 - 256 entries per way, tag, data, flags
// RQ4 - Tag holds upper twenty address bits
// RQ5 - One dirty bit per four-byte word
// RQ6 - Three history bits kept per line
// RQ7 - Line chosen by address bits eleven to four
// RQ8 - Sixteen-byte fill and flush buffers
// RQ9 - Command bits 11:4 select the line
// RQ10 - Op field: buffer, write, read, flush
// RQ11 - Cache read selector picks source way
// RQ12 - Cache write selector picks destination way
// RQ13 - Data read returns selected flush word
// RQ14 - Data write stores selected fill word
// RQ15 - Tag field reports or supplies entry tag
// RQ16 - Bit ten reports or supplies valid flag
// RQ17 - Bits 9:7 report replacement history
// RQ18 - Cache write ignores history field
// RQ19 - Bits 6:3 carry four dirty flags
// RQ20 - Software writes zero to reserved bits
// RQ21 - Data register is full 32 bits
// RQ22 - Flush clears every valid flag
// RQ23 - Software loads four fill words first
// RQ24 - Word index n maps to bits 32n up
// RQ25 - Codes 01-11 start operations, 00 selects
module ctr_port
  import ctr_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Privilege context of the accessing code
  input  wire logic [1:0]        cpl,
  input  wire logic              real_mode,
  // Register access port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [1:0]        reg_sel,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output      logic [DATA_W-1:0] reg_rdata,
  output      logic              reg_fault
);
  ctr_store_if sif ();

  ctr_store u_store (
    .clk (clk),
    .rst (rst),
    .s   (sif)
  );

  // Access permitted only at level zero or in real mode
  logic allowed;
  logic do_wr;
  logic do_rd;
  assign allowed = real_mode || (cpl == 2'h0);  // RQ1
  assign do_wr   = reg_wr && allowed;
  assign do_rd   = reg_rd && allowed;

  // Word slice of a 128-bit buffer
  function automatic logic [31:0] word_of(input logic [127:0] b,
                                          input logic [1:0]   i);
    word_of = b[32*i +: 32];                     // RQ24
  endfunction

  // Register state
  logic [31:0]  cmd_ff,   nxt_cmd;
  logic [31:0]  ts_ff,    nxt_ts;
  logic [127:0] fill_ff,  nxt_fill;
  logic [127:0] flush_ff, nxt_flush;
  logic [31:0]  rdata_ff, nxt_rdata;
  logic         fault_ff, nxt_fault;
  logic         start_wr, start_rd, start_fl;

  ctr_op_t     op_new;
  logic [1:0]  sel_new;
  logic [7:0]  line_new;
  logic [1:0]  cur_sel;
  ctr_op_t     cur_op;

  assign op_new   = ctr_op_t'(reg_wdata[CMD_OP_LSB +: 2]);   // RQ10
  assign sel_new  = reg_wdata[CMD_SEL_LSB +: 2];
  assign line_new = reg_wdata[CMD_LINE_LSB +: IDX_W];        // RQ9
  assign cur_sel  = cmd_ff[CMD_SEL_LSB +: 2];
  assign cur_op   = ctr_op_t'(cmd_ff[CMD_OP_LSB +: 2]);

  // Command write decoding into start strobes
  always_comb begin
    start_wr = 1'b0;
    start_rd = 1'b0;
    start_fl = 1'b0;
    if (do_wr && reg_sel == REG_CMD) begin
      case (op_new)                                           // RQ25
        OP_WRITE: start_wr = 1'b1;
        OP_READ:  start_rd = 1'b1;
        OP_FLUSH: start_fl = 1'b1;
        default:  start_wr = 1'b0;
      endcase
    end
  end

  // Array access driven straight from the command being written
  always_comb begin
    sif.idx    = line_new;                                    // RQ7
    sif.way    = sel_new;                                     // RQ11 RQ12
    sif.wr     = start_wr;
    sif.flush  = start_fl;                                    // RQ22
    sif.wtag   = ts_ff[TS_TAG_LSB +: TAG_W];                  // RQ15
    sif.wvalid = ts_ff[TS_VALID_BIT];                         // RQ16
    sif.wdirty = ts_ff[TS_DIRTY_LSB +: 4];                    // RQ19
    sif.wline  = fill_ff;                                     // RQ8
  end

  // Next register values
  always_comb begin
    nxt_cmd   = cmd_ff;
    nxt_ts    = ts_ff;
    nxt_fill  = fill_ff;
    nxt_flush = flush_ff;
    nxt_rdata = rdata_ff;
    nxt_fault = (reg_wr || reg_rd) && !allowed;               // RQ1
    if (do_wr) begin
      case (reg_sel)
        REG_CMD:  nxt_cmd = {20'h0, reg_wdata[11:0]};
        REG_TAG:  nxt_ts  = {reg_wdata[31:12], 1'b0, reg_wdata[10:3],
                             3'h0};
        REG_DATA: begin
          if (cur_op == OP_BUF) begin
            nxt_fill[32*cur_sel +: 32] = reg_wdata;           // RQ14 RQ21
          end
        end
        default:  nxt_cmd = cmd_ff;
      endcase
    end
    // Cache read loads flush buffer and tag/status image
    if (start_rd) begin
      nxt_flush = sif.rline;                                  // RQ8
      nxt_ts    = {sif.rtag, 1'b0, sif.rvalid, sif.rhist,     // RQ17
                   sif.rdirty, 3'h0};                         // RQ19
    end
    if (do_rd) begin
      case (reg_sel)
        REG_CMD:  nxt_rdata = cmd_ff;
        REG_TAG:  nxt_rdata = ts_ff;
        REG_DATA: nxt_rdata = (cur_op == OP_BUF) ?
                              word_of(flush_ff, cur_sel) :    // RQ13
                              32'h0000_0000;
        default:  nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff   <= CMD_RST;
      ts_ff    <= TS_RST;
      fill_ff  <= 128'h0;
      flush_ff <= 128'h0;
      rdata_ff <= 32'h0000_0000;
      fault_ff <= 1'b0;
    end else begin
      cmd_ff   <= nxt_cmd;
      ts_ff    <= nxt_ts;
      fill_ff  <= nxt_fill;
      flush_ff <= nxt_flush;
      rdata_ff <= nxt_rdata;
      fault_ff <= nxt_fault;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_fault = fault_ff;

  // Checks
  priv_block_a: assert property (@(posedge clk) disable iff (rst) // RQ1
    (reg_wr && !real_mode && cpl != 2'h0)
      |=> $stable(cmd_ff) && $stable(ts_ff) && reg_fault)
    else $error("privileged access not blocked");
  fill_word_a: assert property (@(posedge clk) disable iff (rst) // RQ14
    (do_wr && reg_sel == REG_DATA && cur_op == OP_BUF)
      |=> fill_ff[32*$past(cur_sel) +: 32] == $past(reg_wdata))
    else $error("fill word not stored");
  flush_word_a: assert property (@(posedge clk) disable iff (rst) // RQ13
    (do_rd && reg_sel == REG_DATA && cur_op == OP_BUF)
      |=> reg_rdata == word_of($past(flush_ff), $past(cur_sel)))
    else $error("flush word read wrong");
  read_copy_a: assert property (@(posedge clk) disable iff (rst) // RQ8
    start_rd |=> flush_ff == $past(sif.rline))
    else $error("cache read did not load flush buffer");
  read_tag_a: assert property (@(posedge clk) disable iff (rst) // RQ15
    start_rd |=> ts_ff[31:12] == $past(sif.rtag)
      && ts_ff[10] == $past(sif.rvalid) && ts_ff[6:3] == $past(sif.rdirty))
    else $error("tag status image wrong");
  hist_rpt_a: assert property (@(posedge clk) disable iff (rst) // RQ17
    start_rd |=> ts_ff[9:7] == $past(sif.rhist))
    else $error("history not reported");
  op_start_a: assert property (@(posedge clk) disable iff (rst) // RQ25
    (do_wr && reg_sel == REG_CMD && op_new == OP_BUF)
      |-> !sif.wr && !sif.flush)
    else $error("buffer code started an operation");
  write_back_a: assert property (@(posedge clk) disable iff (rst) // RQ12
    start_wr |=> ##0 (sif.idx != $past(sif.idx) || sif.way != $past(sif.way)
      || sif.rline == $past(fill_ff)))
    else $error("cache write data lost");
  flush_all_a: assert property (@(posedge clk) disable iff (rst) // RQ22
    start_fl |=> !sif.rvalid)
    else $error("flush left entry valid");
  unmap_read_a: assert property (@(posedge clk) disable iff (rst) // RQ21
    (do_rd && reg_sel == 2'h3) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  data_gate_a: assert property (@(posedge clk) disable iff (rst) // RQ13
    (do_rd && reg_sel == REG_DATA && cur_op != OP_BUF)
      |=> reg_rdata == 32'h0000_0000)
    else $error("data read outside buffer mode not zero");
  fill_gate_a: assert property (@(posedge clk) disable iff (rst) // RQ14
    (do_wr && reg_sel == REG_DATA && cur_op != OP_BUF)
      |=> $stable(fill_ff))
    else $error("fill buffer written outside buffer mode");
  ts_rsvd_a: assert property (@(posedge clk) disable iff (rst) // RQ15
    ts_ff[2:0] == 3'h0 && !ts_ff[11])
    else $error("tag status reserved bits set");
  cmd_high_a: assert property (@(posedge clk) disable iff (rst) // RQ9
    cmd_ff[31:12] == 20'h0)
    else $error("command upper bits set");
  fault_idle_a: assert property (@(posedge clk) disable iff (rst) // RQ1
    !(reg_wr || reg_rd) |=> !reg_fault)
    else $error("fault without access");
  rdata_hold_a: assert property (@(posedge clk) disable iff (rst) // RQ21
    !do_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule

// >>> ctr_store.sv
// Cache array: four ways of 256 entries with tag, data, valid, dirty,
// plus three replacement history bits per line. Flip-flop storage.
module ctr_store
  import ctr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Array access
  ctr_store_if.store s
);
  logic [TAG_W-1:0]  tag_ff   [WAYS][LINES]; // RQ2 RQ3
  logic [LINE_W-1:0] data_ff  [WAYS][LINES]; // RQ3
  logic              valid_ff [WAYS][LINES];
  logic [3:0]        dirty_ff [WAYS][LINES];
  logic [2:0]        hist_ff  [LINES];

  // Storage update; history is left untouched by test writes
  always_ff @(posedge clk) begin
    if (rst) begin
      // Whole entry cleared so that an unwritten way reads back as zero
      for (int w = 0; w < WAYS; w++) begin
        for (int l = 0; l < LINES; l++) begin
          tag_ff[w][l]   <= '0;
          data_ff[w][l]  <= '0;
          valid_ff[w][l] <= 1'b0;
          dirty_ff[w][l] <= 4'h0;
        end
      end
    end else if (s.flush) begin
      for (int w = 0; w < WAYS; w++) begin
        for (int l = 0; l < LINES; l++) begin
          valid_ff[w][l] <= 1'b0; // RQ22
        end
      end
    end else if (s.wr) begin
      tag_ff[s.way][s.idx]   <= s.wtag;    // RQ4
      data_ff[s.way][s.idx]  <= s.wline;
      valid_ff[s.way][s.idx] <= s.wvalid;
      dirty_ff[s.way][s.idx] <= s.wdirty;  // RQ5
    end
    if (rst) begin
      for (int l = 0; l < LINES; l++) begin
        hist_ff[l] <= 3'h0;                // RQ6
      end
    end
  end

  // Combinational read of the selected entry
  always_comb begin
    s.rtag   = tag_ff[s.way][s.idx];
    s.rline  = data_ff[s.way][s.idx];
    s.rvalid = valid_ff[s.way][s.idx];
    s.rdirty = dirty_ff[s.way][s.idx];
    s.rhist  = hist_ff[s.idx];             // RQ18
  end
endmodule

// >>> ctr_store_if.sv
// Interface between the register port and the cache array.
// Assumes both sides run on the same core clock.
interface ctr_store_if;
  import ctr_pkg::*;
  logic [7:0]   idx;
  logic [1:0]   way;
  logic         wr;
  logic         flush;
  logic [19:0]  wtag;
  logic         wvalid;
  logic [3:0]   wdirty;
  logic [127:0] wline;
  logic [19:0]  rtag;
  logic         rvalid;
  logic [3:0]   rdirty;
  logic [2:0]   rhist;
  logic [127:0] rline;
  modport port  (output idx, way, wr, flush, wtag, wvalid, wdirty, wline,
                 input  rtag, rvalid, rdirty, rhist, rline);
  modport store (input  idx, way, wr, flush, wtag, wvalid, wdirty, wline,
                 output rtag, rvalid, rdirty, rhist, rline);
endinterface

// >>> testbench.sv
// Self-checking bench for the cache test register port.
// Assumes ctr_pkg and the port with its array are compiled first.
module testbench
  import ctr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        f;
  } ctr_note_t;
  logic        clk;
  logic        rst;
  logic [1:0]  cpl;
  logic        real_mode;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  reg_sel;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_fault;
  ctr_note_t   q[$];
  int          n_fail;
  int          n_tests;
  logic [31:0] w[4];
  logic [31:0] tmp;
  logic [19:0] tag;
  logic [7:0]  line;
  logic [1:0]  way;
  logic [3:0]  dirty;
  logic [31:0] ts_exp;
  ctr_port ctr_port_inst (
    .clk(clk), .rst(rst), .cpl(cpl), .real_mode(real_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_fault(reg_fault)
  );
  // Core clock, 25 ns period
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One access; the note records what the port must answer next cycle
  task automatic acc(input logic w_n, input logic [1:0] sel,
                     input logic [31:0] wd, input logic [31:0] ex,
                     input logic [31:0] m, input logic [1:0] pl,
                     input logic rm);
    ctr_note_t n;
    n.f = (pl != 2'h0) && !rm;
    n.d = ex;
    n.m = (w_n || n.f) ? 32'h0 : m;
    q.push_back(n);
    cpl = pl;
    real_mode = rm;
    reg_wr = w_n;
    reg_rd = !w_n;
    reg_sel = sel;
    reg_wdata = wd;
    @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [1:0] sel, input logic [31:0] d);
    acc(1'b1, sel, d, 32'h0, 32'h0, 2'h0, 1'b0);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [31:0] ex,
                    input logic [31:0] m);
    acc(1'b0, sel, 32'h0, ex, m, 2'h0, 1'b0);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Monitor: takes the oldest note after each access and compares
  initial begin
    ctr_note_t n;
    forever begin
      @(posedge clk);
      if (reg_wr || reg_rd) begin
        #1;
        n = q.pop_front();
        chk("reg_fault", {31'h0, n.f}, {31'h0, reg_fault});
        if (n.m != 32'h0) chk("reg_rdata", n.d & n.m, reg_rdata & n.m);
      end
    end
  end
  // Watchdog
  initial begin
    #(25 * 3000);
    n_fail++;
    conclude();
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cpl = 2'h0;
    real_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 32'h0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(94575));
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    rd(REG_CMD, 32'h0, 32'hFFFF_FFFF);
    rd(REG_TAG, 32'h0, 32'hFFFF_FFFF);
    wr(2'h3, $urandom);
    rd(2'h3, 32'h0, 32'hFFFF_FFFF);
    line = 8'($urandom);
    way = 2'($urandom);
    tag = 20'($urandom);
    dirty = 4'($urandom);
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom;
      tmp = $urandom;
      wr(REG_CMD, {tmp[31:12], 8'h00, 2'(i), 2'b00});
      wr(REG_DATA, w[i]);
    end
    rd(REG_CMD, 32'h0000_000C, 32'hFFFF_FFFF);
    wr(REG_TAG, {tag, 2'b01, 3'b111, dirty, 3'b000});
    wr(REG_CMD, {20'h0, line, way, 2'b01});
    wr(REG_TAG, 32'h0);
    wr(REG_CMD, {20'h0, line, way, 2'b10});
    ts_exp = {tag, 2'b01, 3'b000, dirty, 3'b000};
    rd(REG_TAG, ts_exp, 32'hFFFF_FFFF);
    rd(REG_DATA, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CMD, {28'h0, 2'(i), 2'b00});
      rd(REG_DATA, w[i], 32'hFFFF_FFFF);
    end
    wr(REG_CMD, {20'h0, line, way ^ 2'h1, 2'b10});
    rd(REG_TAG, 32'h0, 32'hFFFF_FFFF);
    acc(1'b1, REG_TAG, 32'hFFFF_FFF8, 32'h0, 32'h0, 2'h3, 1'b0);
    acc(1'b0, REG_TAG, 32'h0, 32'h0, 32'h0, 2'h1, 1'b0);
    rd(REG_TAG, 32'h0, 32'hFFFF_FFFF);
    acc(1'b1, REG_CMD, {20'h0, line, way, 2'b10}, 32'h0, 32'h0, 2'h3,
        1'b1);
    rd(REG_TAG, ts_exp, 32'hFFFF_FFFF);
    wr(REG_CMD, 32'h0000_0003);
    wr(REG_CMD, {20'h0, line, way, 2'b10});
    rd(REG_TAG, 32'h0, 32'h0000_0400);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
